// ---- rtl/led_fade_pkg.sv ----
// Notes on behaviour
// (RQ1) both channels start off, no current
// (RQ2) debounced press turns an off channel on
// (RQ3) turn-on ramps current up over fade time
// (RQ4) press while on ramps current down, then off
// (RQ5) presses during a ramp reverse its direction
// (RQ6) toggle inputs debounced for about 37 ms
// (RQ7) debounce applies to press and release
// (RQ8) each fade walks 63 gamma-corrected levels
// (RQ9) one fade time, 2.5 us per ohm
// (RQ10) grounded fade pin: ramp in about 73 us
// (RQ11) level table 0 to 1000 per mille
// (RQ12) persistent short cuts channel to 20%
// (RQ13) above 130 C derate 3 percent per degree
// (RQ14) above 155 C force both channels off
// (RQ15) no restart until die below 135 C
// (RQ16) parallel outputs need shared toggle signal
// (RQ17) toggle level must hold for debounce window
// (RQ18) short must persist about 5 ms
// (RQ19) equal time per gamma step
package led_fade_pkg;

  // clock and time figures
  localparam int CLK_PERIOD_NS      = 100;
  localparam int DEBOUNCE_TIME_US   = 37000;
  localparam int DEBOUNCE_CYCLES    = (DEBOUNCE_TIME_US * 1000 + CLK_PERIOD_NS - 1)
                                      / CLK_PERIOD_NS;
  localparam int FAULT_PERSIST_US   = 5000;
  localparam int FAULT_CYCLES       = (FAULT_PERSIST_US * 1000 + CLK_PERIOD_NS - 1)
                                      / CLK_PERIOD_NS;
  localparam int FADE_US_PER_OHM_X10 = 25;    // 2.5 us per ohm
  localparam int INSTANT_RAMP_US    = 73;
  localparam int GAMMA_STEPS        = 63;
  // cycles per step for each kilo-ohm of fade resistor
  localparam int FADE_UNIT_CYCLES   = (FADE_US_PER_OHM_X10 * 100000)
                                      / (GAMMA_STEPS * CLK_PERIOD_NS);
  localparam int INSTANT_STEP_CYCLES = (INSTANT_RAMP_US * 1000)
                                      / (GAMMA_STEPS * CLK_PERIOD_NS);

  // counter widths
  localparam int DEB_W   = 19;
  localparam int FAULT_W = 16;
  localparam int UNIT_W  = 9;
  localparam int KOHM_W  = 10;
  localparam int LEVEL_W = 10;
  localparam int INDEX_W = 6;

  // levels in thousandths of the set current
  localparam logic [INDEX_W-1:0] INDEX_MAX   = 6'h3e;
  localparam logic [INDEX_W-1:0] INDEX_RESET = 6'h00;
  localparam logic [LEVEL_W-1:0] LEVEL_RESET = 10'h000;
  localparam logic [LEVEL_W-1:0] FULL_SCALE  = 10'h3e8;
  localparam logic [LEVEL_W-1:0] SHORT_LIMIT = 10'h0c8;   // 20 percent
  localparam logic [12:0]        FULL_SCALE_W = 13'h03e8;
  localparam logic [12:0]        ROLLOFF_SLOPE = 13'h001e; // 30 per mille per degree

  // die temperature thresholds in degrees C
  localparam logic [7:0] ROLLOFF_START_C = 8'h82;
  localparam logic [7:0] SHUTDOWN_C      = 8'h9b;
  localparam logic [7:0] RESTART_C       = 8'h87;

  localparam logic [LEVEL_W-1:0] GAMMA_LEVEL [0:62] = '{
    10'h000, 10'h002, 10'h004, 10'h006, 10'h008, 10'h00a, 10'h00c, 10'h010,
    10'h014, 10'h018, 10'h01c, 10'h020, 10'h024, 10'h02a, 10'h030, 10'h036,
    10'h03c, 10'h042, 10'h048, 10'h050, 10'h058, 10'h060, 10'h068, 10'h070,
    10'h078, 10'h082, 10'h08c, 10'h096, 10'h0a0, 10'h0aa, 10'h0b4, 10'h0c2,
    10'h0d0, 10'h0de, 10'h0ec, 10'h0fa, 10'h108, 10'h11a, 10'h12c, 10'h13e,
    10'h150, 10'h162, 10'h174, 10'h18a, 10'h1a0, 10'h1b6, 10'h1cc, 10'h1e2,
    10'h1f8, 10'h216, 10'h234, 10'h252, 10'h270, 10'h28e, 10'h2ac, 10'h2d2,
    10'h2f8, 10'h31e, 10'h344, 10'h36a, 10'h392, 10'h3bc, 10'h3e8
  };

  // gray order along off, rise, on, fall
  typedef enum logic [1:0] {
    CH_OFF  = 2'h0,
    CH_RISE = 2'h1,
    CH_ON   = 2'h3,
    CH_FALL = 2'h2
  } chan_mode_t;

  typedef struct packed {
    chan_mode_t          mode;
    logic [INDEX_W-1:0]  index;
    logic [FAULT_W-1:0]  fault_cnt;
    logic                fault;
    logic [LEVEL_W-1:0]  current;
  } chan_state_t;

endpackage

// ---- rtl/fade_chan_if.sv ----
`timescale 1ns/1ps
interface fade_chan_if;
  import led_fade_pkg::*;
  logic                raw_n;
  logic                pressed;
  logic                level_n;
  logic [INDEX_W-1:0]  index;
  logic [LEVEL_W-1:0]  level;

  modport debounce (input raw_n, output pressed, output level_n);
  modport table_rd (input index, output level);
  modport ctrl     (output raw_n, output index, input pressed, input level_n, input level);
endinterface

// ---- rtl/toggle_debounce.sv ----
`timescale 1ns/1ps
module toggle_debounce #(
  parameter int HOLD_CYCLES = led_fade_pkg::DEBOUNCE_CYCLES
) (
  input  wire logic         clk_in,
  input  wire logic         reset_in,
  fade_chan_if.debounce     port
);
  import led_fade_pkg::*;

  typedef struct packed {
    logic             level_n;
    logic [DEB_W-1:0] cnt;
    logic             pressed;
  } deb_state_t;

  deb_state_t s;
  deb_state_t next_s;

  // any change of the input restarts the hold count, so bounce never gets through
  always_comb begin
    next_s         = s;
    next_s.pressed = 1'b0;
    if (port.raw_n == s.level_n) begin
      next_s.cnt = '0;
    end else if (s.cnt == DEB_W'(HOLD_CYCLES - 1)) begin
      next_s.cnt     = '0;
      next_s.level_n = port.raw_n;       // RQ7
      next_s.pressed = ~port.raw_n;      // RQ6
    end else begin
      next_s.cnt = s.cnt + 1'b1;
    end
  end

  // released level at reset, so a button held through power-up toggles once the hold count completes
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      s <= '{level_n: 1'b1, cnt: '0, pressed: 1'b0};
    end else begin
      s <= next_s;
    end
  end

  assign port.pressed = s.pressed;
  assign port.level_n = s.level_n;
endmodule

// ---- rtl/gamma_table.sv ----
`timescale 1ns/1ps
module gamma_table (
  input  wire logic         clk_in,
  input  wire logic         reset_in,
  fade_chan_if.table_rd     port
);
  import led_fade_pkg::*;

  typedef struct packed {
    logic [LEVEL_W-1:0] level;
  } tab_state_t;

  tab_state_t s;
  tab_state_t next_s;

  // out-of-range index clamps to full scale rather than reading garbage
  always_comb begin
    next_s = s;
    if (port.index > INDEX_MAX) begin
      next_s.level = GAMMA_LEVEL[INDEX_MAX];
    end else begin
      next_s.level = GAMMA_LEVEL[port.index];   // RQ11
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      s <= '{level: LEVEL_RESET};
    end else begin
      s <= next_s;
    end
  end

  assign port.level = s.level;
endmodule

// ---- rtl/led_fade_top.sv ----
`timescale 1ns/1ps
module led_fade_top #(
  parameter int DEBOUNCE_HOLD = led_fade_pkg::DEBOUNCE_CYCLES,
  parameter int FAULT_HOLD    = led_fade_pkg::FAULT_CYCLES
) (
  input  wire logic                                clk_in,
  input  wire logic                                reset_in,
  input  wire logic [1:0]                          channel_toggle_input_n_in,
  input  wire logic [led_fade_pkg::KOHM_W-1:0]     fade_time_resistor_kohm_in,
  input  wire logic [1:0]                          short_detect_in,
  input  wire logic [7:0]                          die_temp_in,
  output logic      [1:0][led_fade_pkg::LEVEL_W-1:0] channel_current_out,
  output logic      [1:0]                          channel_sourcing_out,
  output logic      [1:0]                          channel_ramping_out,
  output logic      [1:0]                          short_fault_out,
  output logic                                     thermal_rolloff_out,
  output logic                                     thermal_shutdown_out
);
  import led_fade_pkg::*;

  typedef struct packed {
    chan_state_t [1:0]   ch;
    logic [UNIT_W-1:0]   unit_cnt;
    logic [KOHM_W-1:0]   kohm_cnt;
    logic                step;
    logic                shutdown;
    logic                rolloff;
    logic [LEVEL_W-1:0]  scale;
    logic [1:0]          sourcing;
    logic [1:0]          ramping;
  } top_state_t;

  top_state_t s;
  top_state_t next_s;

  logic [1:0]               pressed;
  logic [LEVEL_W-1:0]       level_rd [2];

  fade_chan_if chan_if [2] ();

  // one debouncer and one table reader per channel
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : gen_chan
      assign chan_if[g].raw_n = channel_toggle_input_n_in[g];
      assign chan_if[g].index = s.ch[g].index;
      assign pressed[g]       = chan_if[g].pressed;
      assign level_rd[g]      = chan_if[g].level;

      toggle_debounce #(
        .HOLD_CYCLES (DEBOUNCE_HOLD)
      ) u_debounce (
        .clk_in   (clk_in),
        .reset_in (reset_in),
        .port     (chan_if[g])
      );

      gamma_table u_gamma (
        .clk_in   (clk_in),
        .reset_in (reset_in),
        .port     (chan_if[g])
      );
    end
  endgenerate

  // next state of the whole block
  always_comb begin
    chan_state_t        c;
    logic [19:0]        prod;
    logic [LEVEL_W-1:0] lim;
    logic [12:0]        derate;
    logic               instant;
    logic               unit_wrap;
    c         = '0;
    prod      = '0;
    lim       = '0;
    derate    = '0;
    instant   = 1'b0;
    unit_wrap = 1'b0;
    next_s      = s;
    next_s.step = 1'b0;

    // shared step pacer: both channels and both directions use the same interval
    instant = (fade_time_resistor_kohm_in == '0);
    if (instant) begin
      next_s.kohm_cnt = '0;
      if (s.unit_cnt >= UNIT_W'(INSTANT_STEP_CYCLES - 1)) begin
        next_s.unit_cnt = '0;
        next_s.step     = 1'b1;                                  // RQ10
      end else begin
        next_s.unit_cnt = s.unit_cnt + 1'b1;
      end
    end else begin
      unit_wrap = (s.unit_cnt >= UNIT_W'(FADE_UNIT_CYCLES - 1));
      if (unit_wrap) begin
        next_s.unit_cnt = '0;
        // a resistor shrunk mid-count still wraps at once instead of running long
        if (s.kohm_cnt >= fade_time_resistor_kohm_in - 1'b1) begin
          next_s.kohm_cnt = '0;
          next_s.step     = 1'b1;                                // RQ9 RQ19
        end else begin
          next_s.kohm_cnt = s.kohm_cnt + 1'b1;
        end
      end else begin
        next_s.unit_cnt = s.unit_cnt + 1'b1;
      end
    end

    // thermal shutdown latch with recovery hysteresis
    if (die_temp_in > SHUTDOWN_C) begin
      next_s.shutdown = 1'b1;                                    // RQ14
    end else if (die_temp_in < RESTART_C) begin
      next_s.shutdown = 1'b0;                                    // RQ15
    end

    // linear rolloff factor in thousandths
    next_s.rolloff = (die_temp_in > ROLLOFF_START_C);
    if (next_s.rolloff) begin
      derate = {5'h00, die_temp_in - ROLLOFF_START_C} * ROLLOFF_SLOPE;   // RQ13
    end
    if (derate >= FULL_SCALE_W) begin
      next_s.scale = '0;
    end else begin
      next_s.scale = LEVEL_W'(FULL_SCALE_W - derate);
    end

    for (int i = 0; i < 2; i++) begin
      c = s.ch[i];

      // toggle sequencer; presses are honoured in every mode while shutdown is clear
      case (c.mode)
        CH_OFF: begin
          c.index = INDEX_RESET;
          // locked out while hot: a press is simply dropped
          if (pressed[i] && !s.shutdown) begin
            c.mode = CH_RISE;                                    // RQ2 RQ3
          end
        end
        CH_RISE: begin
          if (pressed[i]) begin
            c.mode = CH_FALL;                                    // RQ5
          end else if (s.step) begin
            c.index = c.index + 1'b1;                            // RQ8
            if (c.index == INDEX_MAX) begin
              c.mode = CH_ON;
            end
          end
        end
        CH_ON: begin
          if (pressed[i]) begin
            c.mode = CH_FALL;                                    // RQ4
          end
        end
        CH_FALL: begin
          if (pressed[i]) begin
            c.mode = CH_RISE;                                    // RQ5
          end else if (s.step) begin
            c.index = c.index - 1'b1;                            // RQ8
            if (c.index == INDEX_RESET) begin
              c.mode = CH_OFF;                                   // RQ4
            end
          end
        end
        default: begin
          c.mode  = CH_OFF;
          c.index = INDEX_RESET;
        end
      endcase

      // overtemperature wins over any toggle state
      if (s.shutdown) begin
        c.mode  = CH_OFF;                                        // RQ14
        c.index = INDEX_RESET;
      end

      // short persistence filter; clears as soon as the output recovers
      if (short_detect_in[i]) begin
        if (c.fault_cnt >= FAULT_W'(FAULT_HOLD - 1)) begin
          c.fault = 1'b1;                                        // RQ12 RQ18
        end else begin
          c.fault_cnt = c.fault_cnt + 1'b1;
        end
      end else begin
        c.fault_cnt = '0;
        c.fault     = 1'b0;                                      // RQ12
      end

      // table level scaled by rolloff, then clipped for a short
      prod = 20'(level_rd[i]) * 20'(s.scale);
      lim  = LEVEL_W'(prod / 20'h003e8);
      if (c.fault && (lim > SHORT_LIMIT)) begin
        lim = SHORT_LIMIT;                                       // RQ12
      end
      // the table read lags one cycle, so shutdown blanks the output directly
      if (s.shutdown) begin
        lim = '0;
      end
      c.current = lim;

      next_s.ch[i] = c;
      // decoded ahead of the register so the status pins never glitch on a mode change
      next_s.sourcing[i] = (c.mode != CH_OFF);
      next_s.ramping[i]  = (c.mode == CH_RISE) || (c.mode == CH_FALL);
    end
  end

  // power-up state: both channels off and dark
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      s <= '0;                                                   // RQ1
      for (int i = 0; i < 2; i++) begin
        s.ch[i].mode    <= CH_OFF;
        s.ch[i].index   <= INDEX_RESET;
        s.ch[i].current <= LEVEL_RESET;
      end
      s.scale <= FULL_SCALE;
    end else begin
      s <= next_s;
    end
  end

  // all outputs come from state flip-flops
  generate
    for (g = 0; g < 2; g++) begin : gen_out
      assign channel_current_out[g]  = s.ch[g].current;
      assign channel_sourcing_out[g] = s.sourcing[g];
      assign channel_ramping_out[g]  = s.ramping[g];
      assign short_fault_out[g]      = s.ch[g].fault;
    end
  endgenerate
  assign thermal_rolloff_out  = s.rolloff;
  assign thermal_shutdown_out = s.shutdown;
endmodule

// ---- test/led_fade_checker.sv ----
`timescale 1ns/1ps
module led_fade_checker
  import led_fade_pkg::*;
#(
  parameter int DEBOUNCE_HOLD = 20,
  parameter int FAULT_HOLD    = 10
) (
  input wire logic                      clk_in,
  input wire logic                      reset_in,
  input wire logic [1:0]                channel_toggle_input_n_in,
  input wire logic [1:0]                short_detect_in,
  input wire logic [7:0]                die_temp_in,
  input wire logic [1:0][LEVEL_W-1:0]   channel_current_out,
  input wire logic [1:0]                channel_sourcing_out,
  input wire logic [1:0]                channel_ramping_out,
  input wire logic [1:0]                short_fault_out,
  input wire logic                      thermal_rolloff_out,
  input wire logic                      thermal_shutdown_out
);
  int low_cnt [2];
  int sh_cnt  [2];
  // run lengths of a held press and of a held short, cleared by any break
  always_ff @(posedge clk_in) begin
    for (int i = 0; i < 2; i++) begin
      low_cnt[i] <= (reset_in || channel_toggle_input_n_in[i]) ? 0 : low_cnt[i] + 1;
      sh_cnt[i]  <= (reset_in || !short_detect_in[i]) ? 0 : sh_cnt[i] + 1;
    end
  end
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);
  // per channel; one slack cycle on counts since the filter edge is internal
  for (genvar i = 0; i < 2; i++) begin : g_ch
    press_held_a: assert property ($rose(channel_sourcing_out[i]) |->
      low_cnt[i] >= DEBOUNCE_HOLD - 1) else $error("turn-on without held press");
    off_quiet_a: assert property (!channel_sourcing_out[i] [*3] |->
      channel_current_out[i] == LEVEL_RESET) else $error("current while off");
    full_level_a: assert property ((channel_sourcing_out[i] && !channel_ramping_out[i]
      && !short_fault_out[i] && !thermal_rolloff_out && !thermal_shutdown_out) [*3]
      |-> channel_current_out[i] == FULL_SCALE) else $error("steady on not full");
    small_step_a: assert property ((channel_ramping_out[i] && !short_fault_out[i]
      && !thermal_rolloff_out) |=>
      int'(channel_current_out[i]) <= int'($past(channel_current_out[i])) + 44 &&
      int'($past(channel_current_out[i])) <= int'(channel_current_out[i]) + 44)
      else $error("ramp jumped");
    short_set_a: assert property ($rose(short_fault_out[i]) |->
      sh_cnt[i] >= FAULT_HOLD - 1) else $error("short flagged early");
    short_clear_a: assert property (!short_detect_in[i] |=> !short_fault_out[i])
      else $error("short not cleared");
    clip_a: assert property (short_fault_out[i] [*3] |->
      channel_current_out[i] <= SHORT_LIMIT) else $error("short not clipped");
  end
  shut_set_a: assert property (die_temp_in > SHUTDOWN_C |=> thermal_shutdown_out)
    else $error("no shutdown when hot");
  shut_off_a: assert property (thermal_shutdown_out [*3] |->
    channel_sourcing_out == 2'h0 && channel_current_out == '0) else $error("on in shutdown");
  hold_off_a: assert property ($fell(thermal_shutdown_out) |->
    $past(die_temp_in) < RESTART_C) else $error("restart while warm");
  rolloff_a: assert property (!$past(reset_in) |->
    thermal_rolloff_out == ($past(die_temp_in) > ROLLOFF_START_C)) else $error("rolloff flag");
endmodule

bind led_fade_top led_fade_checker #(
  .DEBOUNCE_HOLD(DEBOUNCE_HOLD),
  .FAULT_HOLD   (FAULT_HOLD)
) chk_u (
  .clk_in                   (clk_in),
  .reset_in                 (reset_in),
  .channel_toggle_input_n_in(channel_toggle_input_n_in),
  .short_detect_in          (short_detect_in),
  .die_temp_in              (die_temp_in),
  .channel_current_out      (channel_current_out),
  .channel_sourcing_out     (channel_sourcing_out),
  .channel_ramping_out      (channel_ramping_out),
  .short_fault_out          (short_fault_out),
  .thermal_rolloff_out      (thermal_rolloff_out),
  .thermal_shutdown_out     (thermal_shutdown_out)
);

// ---- test/toggle_switch_model.sv ----
`timescale 1ns/1ps
module toggle_switch_model #(
  parameter int BOUNCE = 6
) (
  input  wire logic       clk_in,
  input  wire logic [1:0] press_in,
  output logic      [1:0] toggle_n_out
);
  logic [1:0] held;
  int         left [2];
  initial begin
    toggle_n_out = 2'h3;
    held = 2'h0;
    left = '{0, 0};
  end
  // contacts chatter a few cycles after each change, so the filter is exercised
  always @(negedge clk_in) begin
    for (int i = 0; i < 2; i++) begin
      if (press_in[i] !== held[i]) begin
        held[i] <= press_in[i];
        left[i] <= BOUNCE;
        toggle_n_out[i] <= ~toggle_n_out[i];
      end else if (left[i] > 0) begin
        left[i] <= left[i] - 1;
        toggle_n_out[i] <= ~toggle_n_out[i];
      end else begin
        toggle_n_out[i] <= ~held[i];
      end
    end
  end
endmodule

// ---- test/test_dual_channel_led_fade_toggle.sv ----
`timescale 1ns/1ps
module test_dual_channel_led_fade_toggle;
  import led_fade_pkg::*;
  localparam int HOLD  = 20;
  localparam int FHOLD = 10;
  logic                    clk_in = 1'b0;
  logic                    reset_in;
  logic [1:0]              toggle_n;
  logic [1:0]              press;
  logic [KOHM_W-1:0]       kohm;
  logic [1:0]              shorted;
  logic [7:0]              temp;
  logic [1:0][LEVEL_W-1:0] cur;
  logic [1:0]              src;
  logic [1:0]              ramp;
  logic [1:0]              fault;
  logic                    roll;
  logic                    shut;
  int                      failures;
  int                      n_checks;
  int                      n0;
  int                      n1;
  int                      s0;
  int                      s1;

  led_fade_top #(
    .DEBOUNCE_HOLD(HOLD),
    .FAULT_HOLD   (FHOLD)
  ) dut_u (
    .clk_in                    (clk_in),
    .reset_in                  (reset_in),
    .channel_toggle_input_n_in (toggle_n),
    .fade_time_resistor_kohm_in(kohm),
    .short_detect_in           (shorted),
    .die_temp_in               (temp),
    .channel_current_out       (cur),
    .channel_sourcing_out      (src),
    .channel_ramping_out       (ramp),
    .short_fault_out           (fault),
    .thermal_rolloff_out       (roll),
    .thermal_shutdown_out      (shut)
  );
  toggle_switch_model sw_u (
    .clk_in      (clk_in),
    .press_in    (press),
    .toggle_n_out(toggle_n)
  );

  // 10 MHz clock
  initial begin
    clk_in = 1'b0;
    forever #50 clk_in = ~clk_in;
  end

  task automatic finish_test();
    if (failures == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic chk_bit(string what, logic exp, logic got);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("BAD %s expected %b seen %b", what, exp, got);
    end
  endtask
  task automatic chk_lvl(string what, logic [LEVEL_W-1:0] exp, logic [LEVEL_W-1:0] got);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("BAD %s expected %0d seen %0d", what, exp, got);
    end
  endtask
  task automatic cyc(int n);
    repeat (n) @(negedge clk_in);
  endtask
  // press held well past the filter, then a release held as long
  task automatic push(logic [1:0] m);
    press <= press | m;
    cyc(40);
    press <= press & ~m;
    cyc(40);
  endtask
  // cycles spent ramping and number of current changes seen meanwhile and in the three cycles after
  task automatic ramp_len(int ch, output int n, output int steps);
    logic [LEVEL_W-1:0] prev;
    n = 0;
    steps = 0;
    while (ramp[ch] !== 1'b1 && n < 200) begin
      cyc(1);
      n++;
    end
    prev = cur[ch];
    n = 0;
    while (ramp[ch] === 1'b1 && n < 30000) begin
      cyc(1);
      n++;
      if (cur[ch] !== prev) steps++;
      prev = cur[ch];
    end
    repeat (3) begin
      cyc(1);
      if (cur[ch] !== prev) steps++;
      prev = cur[ch];
    end
  endtask
  task automatic settle(int ch);
    int n;
    n = 0;
    while (ramp[ch] === 1'b1 && n < 30000) begin
      cyc(1);
      n++;
    end
    cyc(4);
  endtask
  task automatic t_fade(int step);
    chk_bit("ramp time", 1'b1, n0 >= 61 * step && n0 <= 62 * step + 2);
    chk_bit("step count", 1'b1, s0 == 62);
    chk_lvl("full level", FULL_SCALE, cur[0]);
  endtask

  task automatic t_glitch();
    press <= 2'h1;
    cyc(14);
    press <= 2'h0;
    cyc(60);
    chk_bit("short press", 1'b0, src[0]);
  endtask
  task automatic t_fade_in();
    fork
      push(2'h1);
      ramp_len(0, n0, s0);
    join
    t_fade(INSTANT_STEP_CYCLES);
  endtask
  // off press, a release too brief to count, then the press goes on
  task automatic t_release_glitch();
    press <= 2'h1;
    cyc(40);
    press <= 2'h0;
    cyc(14);
    press <= 2'h1;
    cyc(40);
    press <= 2'h0;
    settle(0);
    chk_bit("off after fade", 1'b0, src[0]);
    chk_lvl("off level", LEVEL_RESET, cur[0]);
  endtask
  // a second press mid-rise must turn the ramp round, not just keep it going
  task automatic t_reverse();
    logic [LEVEL_W-1:0] v;
    push(2'h1);
    cyc(100);
    push(2'h1);
    v = cur[0];
    cyc(25);
    chk_bit("reversed ramp", 1'b1, ramp[0] && cur[0] < v);
    settle(0);
    chk_bit("reversed to off", 1'b0, src[0]);
  endtask
  // shared input for a paralleled pair, slow fade resistor
  task automatic t_parallel();
    kohm = 10'h001;
    fork
      push(2'h3);
      ramp_len(0, n0, s0);
      ramp_len(1, n1, s1);
    join
    t_fade(FADE_UNIT_CYCLES);
    chk_bit("channels together", 1'b1, n0 == n1 && s1 == 62);
    chk_lvl("second full", FULL_SCALE, cur[1]);
  endtask
  task automatic t_short();
    kohm = 10'h000;
    shorted = 2'h1;
    cyc(FHOLD - 3);
    shorted = 2'h0;
    cyc(5);
    chk_bit("brief short", 1'b0, fault[0]);
    shorted = 2'h1;
    cyc(FHOLD + 5);
    chk_bit("short flag", 1'b1, fault[0]);
    chk_lvl("clipped", SHORT_LIMIT, cur[0]);
    chk_lvl("other channel", FULL_SCALE, cur[1]);
    shorted = 2'h0;
    cyc(5);
    chk_lvl("restored", FULL_SCALE, cur[0]);
  endtask
  task automatic t_thermal();
    temp = 8'h8c;
    cyc(5);
    chk_bit("rolloff flag", 1'b1, roll);
    chk_lvl("derated", 10'h2bc, cur[1]);
    temp = 8'ha0;
    cyc(5);
    chk_bit("shutdown", 1'b1, shut);
    chk_bit("forced off", 1'b0, src[0] | src[1]);
    temp = 8'h8c;
    push(2'h1);
    chk_bit("blocked restart", 1'b0, src[0]);
    temp = 8'h82;
    cyc(3);
    chk_bit("cooled", 1'b0, shut);
    push(2'h1);
    chk_bit("restarted", 1'b1, src[0]);
  endtask
  // two kilo-ohms: neighbouring steps sit exactly two units apart
  task automatic t_slow_step();
    int n;
    n = 0;
    kohm = 10'h002;
    fork
      push(2'h2);
      begin
        while (cur[1] === LEVEL_RESET && n < 2000) begin
          cyc(1);
          n++;
        end
        n = 0;
        while (cur[1] === GAMMA_LEVEL[1] && n < 2000) begin
          cyc(1);
          n++;
        end
      end
    join
    chk_bit("step interval", 1'b1, n == 2 * FADE_UNIT_CYCLES);
  endtask

  // a hang is cut short well beyond the planned run length
  initial begin
    #6000000;
    failures++;
    finish_test();
  end
  initial begin
    failures = 0;
    n_checks = 0;
    press = 2'h0;
    kohm = 10'h000;
    shorted = 2'h0;
    temp = 8'h19;
    reset_in = 1'b1;
    cyc(4);
    reset_in = 1'b0;
    cyc(2);
    chk_bit("off at reset", 1'b0, src[0] | src[1]);
    chk_lvl("zero at reset", LEVEL_RESET, cur[0] | cur[1]);
    t_glitch();
    t_fade_in();
    t_release_glitch();
    t_reverse();
    t_parallel();
    t_short();
    t_thermal();
    t_slow_step();
    finish_test();
  end
endmodule
